// *** src/fes_consts.vh ***
// constants for the flash erase / lock / blank-check command sequencer
// assumes an apb master with 32-bit data and one clock at 200 MHz
`ifndef FES_CONSTS_VH
`define FES_CONSTS_VH

// apb byte offsets
`define FES_OFS_CMD 12'h000
`define FES_OFS_STATUS 12'h004
`define FES_OFS_MODE1 12'h008
`define FES_OFS_MODE2 12'h00C
`define FES_OFS_RDATA 12'h010
`define FES_OFS_LOCKS 12'h014

// command word fields of the cmd register
`define FES_CMD_DATA_LSB 0
`define FES_CMD_ADDR_LSB 8

// command codes
`define FES_CODE_READ 8'hFF
`define FES_CODE_CLEAR 8'h50
`define FES_CODE_ERASE 8'h20
`define FES_CODE_LOCKPRG 8'h77
`define FES_CODE_LOCKRD 8'h71
`define FES_CODE_BLANK 8'h25
`define FES_CODE_CONFIRM 8'hD0
`define FES_ERASED 8'hFF
// array content before the first erase: programmed, not blank
`define FES_INIT_BYTE 8'h00

// status register bits
`define FES_ST_LOCKRD 0
`define FES_ST_PRGERR 4
`define FES_ST_ERSERR 5
`define FES_ST_SUSP 6
`define FES_ST_READY 7
`define FES_ST_IRQ 8

// mode one bits
`define FES_M1_LOCKDIS 3
`define FES_M1_INH_LSB 4
// mode two bits
`define FES_M2_IRQEN 0
`define FES_M2_SUSPEN 1
`define FES_M2_SUSPREQ 2
`define FES_M2_AUTOSUSP 3

// timing: one internal step per byte, lock bit write time
`define FES_LOCK_NS 100
`define FES_CLK_NS 5
`define FES_LOCK_CYC ((`FES_LOCK_NS + `FES_CLK_NS - 1) / `FES_CLK_NS)

`endif

// *** src/fes_sequencer.v ***
// flash erase, lock bit and blank check command sequencer with apb slave
// assumes apb master on sys_clk_i; array model held in local memory
`timescale 1ns/100ps
`default_nettype none
`include "fes_consts.vh"

module fes_sequencer #(
    parameter BLK_BITS = 3,         // number of blocks is 2**BLK_BITS
    parameter OFS_BITS = 4,         // bytes per block is 2**OFS_BITS
    parameter DATA_BLK_BASE = 4     // blocks from here up are data a..d
) (
    input wire sys_clk_i,
    input wire nrst_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    input wire irq_req_i,           // any interrupt request in the system
    output reg ready_irq_o          // flash ready status interrupt pulse
);

    localparam AW = BLK_BITS + OFS_BITS;
    localparam NBLK = 1 << BLK_BITS;
    localparam [OFS_BITS-1:0] OFS_LAST = {OFS_BITS{1'b1}};
    localparam [7:0] LOCK_CYC = `FES_LOCK_CYC;

    // sequencer states
    localparam [2:0] S_IDLE = 3'd0;
    localparam [2:0] S_SECOND = 3'd1;   // first cycle code held
    localparam [2:0] S_ERASE = 3'd2;
    localparam [2:0] S_SUSP = 3'd3;
    localparam [2:0] S_BLANK = 3'd4;
    localparam [2:0] S_LOCKW = 3'd5;

    ////////////////////////////////////////////////////////////////////
    // storage
    reg [7:0] array_q [0:(1<<AW)-1];    // flash array bytes
    reg [NBLK-1:0] lock_q;              // 0 means locked
    reg [2:0] state_q;
    reg [7:0] code_q;                   // pending first-cycle code
    reg [BLK_BITS-1:0] blk_q;           // target or suspended block
    reg [OFS_BITS-1:0] ofs_q;           // walking byte offset
    reg [7:0] wait_q;                   // lock write timer
    reg ready_q, prg_err_q, ers_err_q, lockrd_q, fail_q;
    reg lockdis_q;
    reg [3:0] inhibit_q;                // data blocks a..d
    reg irqen_q, suspen_q, suspreq_q, autosusp_q;
    reg [7:0] rdata_q;                  // read array result
    reg irq_flag_q;                     // sticky view of the last irq
    integer i;
    // suspended erase pending behind a lock command
    reg susp_hold_q;
    reg [BLK_BITS-1:0] cmd_blk_lk_q;    // block of the last second-cycle command write
    wire susp_hold = susp_hold_q;
    wire blk_valid_susp = susp_hold_q;

    // apb write strobe taken on the access-phase edge
    wire wr = psel_i & penable_i & pwrite_i;
    wire cmd_wr = wr && (paddr_i == `FES_OFS_CMD);
    wire [7:0] cmd_data = pwdata_i[`FES_CMD_DATA_LSB +: 8];
    wire [AW-1:0] cmd_addr = pwdata_i[`FES_CMD_ADDR_LSB +: AW];
    wire [BLK_BITS-1:0] cmd_blk = cmd_addr[AW-1:OFS_BITS];

    // true when the block is refused for erase
    function refused;
        input [BLK_BITS-1:0] b;
        begin
            refused = 1'b0;
            if (b >= DATA_BLK_BASE && b < DATA_BLK_BASE + 4) begin
                refused = inhibit_q[b - DATA_BLK_BASE];
            end else if (!lockdis_q && !lock_q[b]) begin
                refused = 1'b1;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // command sequencer
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= S_IDLE;
            code_q <= 8'h00;
            blk_q <= {BLK_BITS{1'b0}};
            ofs_q <= {OFS_BITS{1'b0}};
            wait_q <= 8'h00;
            ready_q <= 1'b1;
            prg_err_q <= 1'b0;
            ers_err_q <= 1'b0;
            lockrd_q <= 1'b0;
            fail_q <= 1'b0;
            lock_q <= {NBLK{1'b1}};
            lockdis_q <= 1'b0;
            inhibit_q <= 4'h0;
            irqen_q <= 1'b0;
            suspen_q <= 1'b0;
            suspreq_q <= 1'b0;
            autosusp_q <= 1'b0;
            ready_irq_o <= 1'b0;
            irq_flag_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            ready_irq_o <= 1'b0;
            // mode register writes
            if (wr && paddr_i == `FES_OFS_MODE1) begin
                lockdis_q <= pwdata_i[`FES_M1_LOCKDIS];
                inhibit_q <= pwdata_i[`FES_M1_INH_LSB +: 4];
            end
            if (wr && paddr_i == `FES_OFS_MODE2) begin
                irqen_q <= pwdata_i[`FES_M2_IRQEN];
                suspen_q <= pwdata_i[`FES_M2_SUSPEN];
                suspreq_q <= pwdata_i[`FES_M2_SUSPREQ];
                autosusp_q <= pwdata_i[`FES_M2_AUTOSUSP];
            end
            // hardware set wins over a software write in the same cycle
            if (state_q == S_ERASE && autosusp_q && irq_req_i) begin
                suspreq_q <= 1'b1;
            end
            if (wr && paddr_i == `FES_OFS_STATUS &&
                    pwdata_i[`FES_ST_IRQ]) begin
                irq_flag_q <= 1'b0;
            end
            case (state_q)
                S_IDLE, S_SUSP: begin
                    // resume when software drops the suspend request
                    if (state_q == S_SUSP && !suspreq_q) begin
                        state_q <= S_ERASE;
                        ready_q <= 1'b0;
                    end else if (cmd_wr) begin
                        case (cmd_data)
                            `FES_CODE_READ: begin
                                rdata_q <= array_q[cmd_addr];
                            end
                            `FES_CODE_CLEAR: begin
                                prg_err_q <= 1'b0;
                                ers_err_q <= 1'b0;
                            end
                            `FES_CODE_ERASE, `FES_CODE_LOCKPRG,
                            `FES_CODE_LOCKRD, `FES_CODE_BLANK: begin
                                code_q <= cmd_data;
                                if (state_q == S_IDLE) begin
                                    state_q <= S_SECOND;
                                end else if (cmd_data == `FES_CODE_ERASE)
                                        begin
                                    prg_err_q <= 1'b1;
                                    ers_err_q <= 1'b1;
                                end else begin
                                    // lock and blank check commands allowed in suspend
                                    state_q <= S_SECOND;
                                end
                            end
                            default: begin
                                prg_err_q <= 1'b1;
                                ers_err_q <= 1'b1;
                            end
                        endcase
                    end
                end
                S_SECOND: begin
                    if (cmd_wr) begin
                        // return to idle, or to suspend if one is held
                        state_q <= (suspreq_q && ready_q && !fail_q &&
                            code_q != `FES_CODE_ERASE && blk_valid_susp)
                            ? S_SUSP : S_IDLE;
                        if (cmd_data == `FES_CODE_READ) begin
                            code_q <= 8'h00;
                        end else if (cmd_data != `FES_CODE_CONFIRM ||
                                (susp_hold && cmd_blk == blk_q)) begin
                            prg_err_q <= 1'b1;
                            ers_err_q <= 1'b1;
                        end else begin
                            case (code_q)
                                `FES_CODE_ERASE: begin
                                    if (!refused(cmd_blk)) begin
                                        blk_q <= cmd_blk;
                                        ofs_q <= {OFS_BITS{1'b0}};
                                        ready_q <= 1'b0;
                                        fail_q <= 1'b0;
                                        state_q <= S_ERASE;
                                    end
                                end
                                `FES_CODE_LOCKPRG: begin
                                    lock_q[cmd_blk] <= 1'b0;
                                    blk_q <= susp_hold ? blk_q : cmd_blk;
                                    wait_q <= LOCK_CYC;
                                    ready_q <= 1'b0;
                                    state_q <= S_LOCKW;
                                end
                                `FES_CODE_LOCKRD: begin
                                    lockrd_q <= lock_q[cmd_blk];
                                end
                                default: begin
                                    blk_q <= cmd_blk;
                                    ofs_q <= {OFS_BITS{1'b0}};
                                    ready_q <= 1'b0;
                                    fail_q <= 1'b0;
                                    state_q <= S_BLANK;
                                end
                            endcase
                        end
                    end
                end
                S_ERASE: begin
                    if (suspen_q && suspreq_q) begin
                        state_q <= S_SUSP;
                        ready_q <= 1'b1;
                        ready_irq_o <= irqen_q;
                        irq_flag_q <= irq_flag_q | irqen_q;
                    end else begin
                        array_q[{blk_q, ofs_q}] <= `FES_ERASED;
                        ofs_q <= ofs_q + 1'b1;
                        if (ofs_q == OFS_LAST) begin
                            state_q <= S_IDLE;
                            ready_q <= 1'b1;
                            lockdis_q <= 1'b0;
                            lock_q[blk_q] <= 1'b1;
                            ers_err_q <= 1'b0;
                            ready_irq_o <= irqen_q;
                            irq_flag_q <= irq_flag_q | irqen_q;
                        end
                    end
                end
                S_BLANK: begin
                    if (array_q[{blk_q, ofs_q}] != `FES_ERASED) begin
                        fail_q <= 1'b1;
                    end
                    ofs_q <= ofs_q + 1'b1;
                    if (ofs_q == OFS_LAST) begin
                        state_q <= S_IDLE;
                        ready_q <= 1'b1;
                        if (fail_q || array_q[{blk_q, ofs_q}] !=
                                `FES_ERASED) begin
                            ers_err_q <= 1'b1;
                            prg_err_q <= 1'b0;
                        end
                        ready_irq_o <= irqen_q;
                        irq_flag_q <= irq_flag_q | irqen_q;
                    end
                end
                S_LOCKW: begin
                    wait_q <= wait_q - 8'h01;
                    if (wait_q == 8'h01) begin
                        state_q <= suspreq_q && susp_hold ? S_SUSP : S_IDLE;
                        ready_q <= 1'b1;
                        if (lock_q[cmd_blk_lk_q]) begin
                            prg_err_q <= 1'b1;
                            ers_err_q <= 1'b0;
                        end
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // track a held suspend and the block a lock write aimed at
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            susp_hold_q <= 1'b0;
            cmd_blk_lk_q <= {BLK_BITS{1'b0}};
        end else begin
            if (state_q == S_SUSP) begin
                susp_hold_q <= 1'b1;
            end else if (state_q == S_ERASE || state_q == S_IDLE) begin
                susp_hold_q <= 1'b0;
            end
            if (cmd_wr && state_q == S_SECOND) begin
                cmd_blk_lk_q <= cmd_blk;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // apb answer: zero wait states, unmapped reads give zero and slverr
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prdata_o <= 32'h00000000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= psel_i & ~penable_i;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h00000000;
            if (psel_i && !penable_i) begin
                case (paddr_i)
                    `FES_OFS_CMD: prdata_o <= 32'h00000000;
                    `FES_OFS_STATUS: prdata_o <= {23'h0, irq_flag_q,
                        ready_q, state_q == S_SUSP, ers_err_q, prg_err_q,
                        3'h0, lockrd_q};
                    `FES_OFS_MODE1: prdata_o <= {24'h0, inhibit_q,
                        lockdis_q, 3'h0};
                    `FES_OFS_MODE2: prdata_o <= {28'h0, autosusp_q,
                        suspreq_q, suspen_q, irqen_q};
                    `FES_OFS_RDATA: prdata_o <= {24'h0, rdata_q};
                    `FES_OFS_LOCKS: prdata_o <= {{(32-NBLK){1'b0}}, lock_q};
                    default: pslverr_o <= 1'b1;
                endcase
            end
        end
    end

    // array starts programmed, so erase and blank check have work to show
    initial begin
        for (i = 0; i < (1<<AW); i = i + 1) begin
            array_q[i] = `FES_INIT_BYTE;
        end
    end

endmodule // fes_sequencer
`default_nettype wire

// *** testbench/fes_sequencer_asserts.sv ***
// port checker for the flash command sequencer
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/100ps
`default_nettype none
`include "fes_consts.vh"

module fes_sequencer_asserts (
    input wire sys_clk_i,
    input wire nrst_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire pready_o,
    input wire pslverr_o,
    input wire irq_req_i,
    input wire ready_irq_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    // six aligned words make up the map
    wire mapped_w = (paddr_i <= `FES_OFS_LOCKS) && (paddr_i[1:0] == 2'b00);
    // confirm code accepted into the command word
    wire cfm_w = psel_i && penable_i && pwrite_i && pready_o &&
        (paddr_i == `FES_OFS_CMD) && (pwdata_i[7:0] == `FES_CODE_CONFIRM);
    // last written suspend enable; a suspend may pulse the irq at once
    logic susp_en_q;
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            susp_en_q <= 1'b0;
        end else if (psel_i && penable_i && pwrite_i && pready_o &&
                paddr_i == `FES_OFS_MODE2) begin
            susp_en_q <= pwdata_i[`FES_M2_SUSPEN];
        end
    end

    ////////////////////////////////////////////////////////////////////
    a_setup_answer: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no answer in access cycle");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    a_ready_access: assert property (pready_o |-> psel_i && penable_i)
        else $error("pready outside access phase");
    a_err_decode: assert property (pready_o |-> pslverr_o == !mapped_w)
        else $error("pslverr disagrees with address map");
    a_err_alone: assert property (!pready_o |-> !pslverr_o)
        else $error("pslverr without pready");
    a_irq_pulse: assert property (ready_irq_o |=> !ready_irq_o)
        else $error("ready interrupt longer than one cycle");
    a_irq_not_early: assert property (cfm_w && !susp_en_q |=>
        !ready_irq_o [*8])
        else $error("ready interrupt before operation could finish");
    a_reset_quiet: assert property ($rose(nrst_i) |->
        !pready_o && !pslverr_o && !ready_irq_o)
        else $error("outputs active right after reset");

    // main scenarios reached
    c_confirm: cover property (cfm_w);
    c_irq: cover property (ready_irq_o);
    c_unmapped: cover property (pready_o && pslverr_o);
endmodule // fes_sequencer_asserts

bind fes_sequencer fes_sequencer_asserts u_chk (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .irq_req_i(irq_req_i),
    .ready_irq_o(ready_irq_o));
`default_nettype wire

// *** testbench/fes_host_model.sv ***
// cpu model issuing command writes over apb
// assumes tasks are entered just after a rising edge
`timescale 1ns/100ps
`default_nettype none
`include "fes_consts.vh"

module fes_host_model (
    input wire logic clk_i,
    input wire logic pready_i,
    input wire logic pslverr_i,
    input wire logic [31:0] prdata_i,
    output var logic psel_o,
    output var logic penable_o,
    output var logic pwrite_o,
    output var logic [11:0] paddr_o,
    output var logic [31:0] pwdata_o,
    output var logic irq_o
);
    logic [31:0] dum_q;
    logic dume_q;

    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 12'h000;
        pwdata_o = 32'h00000000;
        irq_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // one apb transfer; request held until pready is sampled high
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
              output logic [31:0] r, output logic e);
        psel_o <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        @(posedge clk_i);
        while (pready_i !== 1'b1) @(posedge clk_i);
        r = prdata_i;
        e = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        // stale data must not look valid once released
        pwdata_o <= ~d;
        @(posedge clk_i);
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, dum_q, dume_q);
    endtask

    // single-cycle command: code with target byte address
    task cmd1(input logic [7:0] code, input logic [6:0] addr);
        wr(`FES_OFS_CMD, {17'h0, addr, code});
    endtask

    // two-cycle command, same address in both cycles
    // callers keep blank check out of suspend and own block
    task cmd2(input logic [7:0] code, input logic [6:0] addr,
              input logic [7:0] d2);
        cmd1(code, addr);
        cmd1(d2, addr);
    endtask

    // system interrupt request level; auto suspend set first
    task set_irq(input logic v);
        irq_o <= v;
        @(posedge clk_i);
    endtask
endmodule // fes_host_model
`default_nettype wire

// *** testbench/flash_erase_lock_blank_sequencer_test.sv ***
// self-checking bench for the flash command sequencer
// assumes fes_host_model as cpu and the bound port checker
`timescale 1ns/100ps
`default_nettype none
`include "fes_consts.vh"

module flash_erase_lock_blank_sequencer_test;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    wire psel, pen, pwr, prdy, perr, irq, rirq;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata;
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;
    int irq_cnt = 0;
    logic [31:0] rnd = 32'h00005547;
    logic [31:0] r;
    logic e;
    logic [1:0] blk;
    int k;

    fes_sequencer uut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(prdy),
        .pslverr_o(perr), .irq_req_i(irq), .ready_irq_o(rirq));
    fes_host_model h (.clk_i(sys_clk_i), .pready_i(prdy), .pslverr_i(perr),
        .prdata_i(prdata), .psel_o(psel), .penable_o(pen), .pwrite_o(pwr),
        .paddr_o(paddr), .pwdata_o(pwdata), .irq_o(irq));

    initial forever #2.5 sys_clk_i = ~sys_clk_i;

    ////////////////////////////////////////////////////////////////////
    // interrupt pulses counted; run cut short if it hangs
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (rirq === 1'b1) irq_cnt <= irq_cnt + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            end_of_test();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // poll status until a bit reaches the wanted level, bounded
    task wait_bit(input int b, input logic v);
        int i;
        for (i = 0; i < 100; i++) begin
            h.xfer(1'b0, `FES_OFS_STATUS, 32'h0, r, e);
            if (r[b] === v) break;
        end
        // running out of polls counts against the run
        if (i == 100) begin
            n_mismatch++;
            $display("ERROR status bit %0d never reached %b", b, v);
        end
    endtask

    task end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        @(posedge sys_clk_i);
        h.xfer(1'b0, `FES_OFS_STATUS, 32'h0, r, e);
        chk("reset status", r[7:4], 4'h8);
        h.xfer(1'b0, `FES_OFS_LOCKS, 32'h0, r, e);
        chk("reset locks", r[7:0], 8'hFF);
        h.xfer(1'b0, 12'h018, 32'h0, r, e);
        chk("unmapped err", e, 1'b1);
        // erase a random program block with interrupt enabled
        rnd = lfsr(rnd);
        blk = rnd[1:0];
        h.wr(`FES_OFS_MODE2, 32'h1);
        h.cmd2(`FES_CODE_ERASE, {1'b0, blk, 4'h0}, `FES_CODE_CONFIRM);
        h.xfer(1'b0, `FES_OFS_STATUS, 32'h0, r, e);
        chk("erase busy", r[7], 1'b0);
        wait_bit(7, 1'b1);
        chk("erase errs", r[5:4], 2'b00);
        chk("erase irq", irq_cnt, 1);
        chk("irq flag", r[8], 1'b1);
        for (k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            h.cmd1(`FES_CODE_READ, {1'b0, blk, rnd[3:0]});
            h.xfer(1'b0, `FES_OFS_RDATA, 32'h0, r, e);
            chk("erased byte", r[7:0], 8'hFF);
        end
        // lock block 1, read it back, then protected erase refused
        h.cmd2(`FES_CODE_LOCKPRG, 7'h10, `FES_CODE_CONFIRM);
        h.xfer(1'b0, `FES_OFS_STATUS, 32'h0, r, e);
        chk("lock busy", r[7], 1'b0);
        wait_bit(7, 1'b1);
        chk("lock errs", r[5:4], 2'b00);
        h.xfer(1'b0, `FES_OFS_LOCKS, 32'h0, r, e);
        chk("lock bit", r[1:0], 2'b01);
        h.cmd2(`FES_CODE_LOCKRD, 7'h10, `FES_CODE_CONFIRM);
        wait_bit(7, 1'b1);
        chk("readout locked", r[0], 1'b0);
        h.cmd2(`FES_CODE_LOCKRD, 7'h00, `FES_CODE_CONFIRM);
        wait_bit(7, 1'b1);
        chk("readout free", r[0], 1'b1);
        h.cmd2(`FES_CODE_ERASE, 7'h10, `FES_CODE_CONFIRM);
        wait_bit(7, 1'b1);
        h.xfer(1'b0, `FES_OFS_LOCKS, 32'h0, r, e);
        chk("locked kept", r[1], 1'b0);
        h.wr(`FES_OFS_MODE1, 32'h8);
        h.cmd2(`FES_CODE_ERASE, 7'h10, `FES_CODE_CONFIRM);
        wait_bit(7, 1'b1);
        h.xfer(1'b0, `FES_OFS_LOCKS, 32'h0, r, e);
        chk("unlock by erase", r[1], 1'b1);
        h.xfer(1'b0, `FES_OFS_MODE1, 32'h0, r, e);
        chk("protect rearmed", r[3], 1'b0);
        // each inhibited data block refuses erase
        for (k = 0; k < 4; k++) begin
            h.wr(`FES_OFS_MODE1, 32'h10 << k);
            h.cmd2(`FES_CODE_ERASE, 7'h40 + 7'(k * 16), `FES_CODE_CONFIRM);
            h.xfer(1'b0, `FES_OFS_STATUS, 32'h0, r, e);
            chk("inhibit ready", r[7], 1'b1);
        end
        h.wr(`FES_OFS_MODE1, 32'h0);
        // bad confirm, clear, cancel by read array
        h.cmd2(`FES_CODE_ERASE, 7'h00, 8'h33);
        wait_bit(7, 1'b1);
        chk("seq error", r[5:4], 2'b11);
        h.cmd1(`FES_CODE_CLEAR, 7'h00);
        wait_bit(7, 1'b1);
        chk("cleared", r[5:4], 2'b00);
        h.cmd2(`FES_CODE_ERASE, 7'h00, `FES_CODE_READ);
        h.xfer(1'b0, `FES_OFS_STATUS, 32'h0, r, e);
        chk("cancel", {r[7], r[5:4]}, 3'b100);
        // blank check of the erased block
        h.cmd2(`FES_CODE_BLANK, {1'b0, blk, 4'h5}, `FES_CODE_CONFIRM);
        h.xfer(1'b0, `FES_OFS_STATUS, 32'h0, r, e);
        chk("blank busy", r[7], 1'b0);
        wait_bit(7, 1'b1);
        chk("blank ok", r[5:4], 2'b00);
        // a never-erased data block still holds programmed bytes
        h.cmd2(`FES_CODE_BLANK, 7'h60, `FES_CODE_CONFIRM);
        wait_bit(7, 1'b1);
        chk("blank fail", r[5:4], 2'b10);
        h.cmd1(`FES_CODE_CLEAR, 7'h00);
        // suspend by request, erase during suspend, resume
        k = irq_cnt;
        h.wr(`FES_OFS_MODE2, 32'h3);
        h.cmd2(`FES_CODE_ERASE, 7'h20, `FES_CODE_CONFIRM);
        h.wr(`FES_OFS_MODE2, 32'h7);
        wait_bit(6, 1'b1);
        chk("suspended", r[6], 1'b1);
        chk("suspend irq", irq_cnt, k + 1);
        h.cmd2(`FES_CODE_ERASE, 7'h30, `FES_CODE_CONFIRM);
        h.xfer(1'b0, `FES_OFS_STATUS, 32'h0, r, e);
        chk("erase in suspend", r[5:4], 2'b11);
        h.cmd1(`FES_CODE_CLEAR, 7'h00);
        h.wr(`FES_OFS_MODE2, 32'h3);
        wait_bit(7, 1'b1);
        chk("resumed", r[6], 1'b0);
        // interrupt request suspends on its own
        h.wr(`FES_OFS_MODE2, 32'hA);
        h.cmd2(`FES_CODE_ERASE, 7'h20, `FES_CODE_CONFIRM);
        h.set_irq(1'b1);
        wait_bit(6, 1'b1);
        chk("auto suspend", r[6], 1'b1);
        h.set_irq(1'b0);
        h.xfer(1'b0, `FES_OFS_MODE2, 32'h0, r, e);
        chk("request set", r[2], 1'b1);
        h.wr(`FES_OFS_MODE2, 32'h2);
        wait_bit(7, 1'b1);
        chk("auto resumed", r[6:4], 3'b000);
        end_of_test();
    end
endmodule // flash_erase_lock_blank_sequencer_test
`default_nettype wire
